/* File: hdl/fpu_pkg.sv */
// constants, encodings and latencies of the long compare and double fpu path
// Function
// - long compare writes rB minus rA, one cycle
// - result msb set exactly when rA exceeds rB
// - sign-mode bit one means unsigned compare
// - denormal operand flags and cause first
// - add invalid: sNaN or opposite infinities
// - checks in fixed priority before normal result
// - denormal result gives signed zero, underflow
// - overflow gives signed infinity, overflow flag
// - fp exception suppresses destination write, except double compare
// - cause written only on fp exception
// - add, rsub, mul take 4/6/1 cycles
// - reverse subtract computes rB minus rA
// - rsub invalid: sNaN or same-sign infinities
// - multiply invalid: sNaN or zero times infinity
// - divide computes rB divided by rA
// - divide invalid: sNaN, zero/zero, inf/inf
// - zero divisor, finite dividend: divide-by-zero
// - divide takes 28/30/24 cycles
// - compare decoded from opcode plus type bits
// - compare type encodings un..ge 000..110
// - compare with denormal writes zero, flags
package fpu_pkg;

  // instruction decode; instruction bit 0 is the lsb, instr_i[0]
  localparam logic [5:0]  OPC_CMPL     = 6'h05;
  localparam logic [5:0]  OPC_FPU      = 6'h16;
  localparam logic [10:0] FN_CMPL      = 11'h101;
  localparam logic [10:0] FN_CMPL_MASK = 11'h7fd;
  localparam int          CMPL_U_BIT   = 1;
  localparam logic [10:0] FN_DADD      = 11'h400;
  localparam logic [10:0] FN_DRSUB     = 11'h480;
  localparam logic [10:0] FN_DMUL      = 11'h500;
  localparam logic [10:0] FN_DDIV      = 11'h580;
  localparam logic [3:0]  FN_DCMP_HI   = 4'hc;
  localparam int          CMP_TYPE_LSB = 4;

  typedef enum logic [2:0] {
    CT_UN = 3'h0, CT_LT = 3'h1, CT_EQ = 3'h2, CT_LE = 3'h3,
    CT_GT = 3'h4, CT_NE = 3'h5, CT_GE = 3'h6
  } cmp_type_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_CMPL = 3'h1, OP_DADD = 3'h2, OP_DRSUB = 3'h3,
    OP_DMUL = 3'h4, OP_DDIV = 3'h5, OP_DCMP = 3'h6
  } op_t;

  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} state_t;

  // area-optimisation settings held in the control register
  localparam logic [1:0] MODE_SPEED = 2'h0;
  localparam logic [1:0] MODE_AREA  = 2'h1;
  localparam logic [1:0] MODE_FAST  = 2'h2;
  localparam logic [1:0] MODE_RST   = MODE_SPEED;

  localparam logic [4:0] LAT_CMPL       = 5'h01;
  localparam logic [4:0] LAT_ARITH_SPD  = 5'h04;
  localparam logic [4:0] LAT_ARITH_AREA = 5'h06;
  localparam logic [4:0] LAT_ARITH_FAST = 5'h01;
  localparam logic [4:0] LAT_DIV_SPD    = 5'h1c;
  localparam logic [4:0] LAT_DIV_AREA   = 5'h1e;
  localparam logic [4:0] LAT_DIV_FAST   = 5'h18;
  localparam logic [4:0] LAT_DCMP_SPD   = 5'h01;
  localparam logic [4:0] LAT_DCMP_AREA  = 5'h03;
  localparam logic [4:0] LAT_DCMP_FAST  = 5'h01;

  // status flag positions and the fp exception cause
  localparam int         FLG_W  = 5;
  localparam int         FLG_DO = 0;
  localparam int         FLG_UN = 1;
  localparam int         FLG_OV = 2;
  localparam int         FLG_DV = 3;
  localparam int         FLG_IO = 4;
  localparam logic [4:0] EXC_CAUSE_FP = 5'h06;
  localparam logic [4:0] CAUSE_RST    = 5'h00;
  localparam logic [4:0] STATUS_RST   = 5'h00;

  // apb register map
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CAUSE  = 12'h008;

  // double format
  localparam logic [10:0]        EXP_ALL1 = 11'h7ff;
  localparam logic signed [13:0] EXP_INF  = 14'sh07ff;
  localparam logic signed [13:0] BIAS     = 14'sh03ff;
  localparam logic [63:0]        QNAN     = 64'h7ff8000000000000;
  localparam logic [1:0]         KIND_OK  = 2'h0;
  localparam logic [1:0]         KIND_LO  = 2'h1;
  localparam logic [1:0]         KIND_HI  = 2'h2;

endpackage

/* File: hdl/long_compare_double_fpu.sv */
// long integer compare and double add, rsub, mul, div, compare datapath
`timescale 1ns/100ps
module long_compare_double_fpu
  import fpu_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // issue from the pipeline
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [63:0] src_a_i,
  input  wire logic [63:0] src_b_i,
  // result to the register file
  output logic             busy_o,
  output logic             done_o,
  output logic             wr_en_o,
  output logic [63:0]      result_o,
  output logic             fp_exc_o,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  function automatic logic is_dnz(input logic [63:0] x);
    is_dnz = (x[62:52] == 11'h000) && (x[51:0] != 52'h0);
  endfunction
  function automatic logic is_zero(input logic [63:0] x);
    is_zero = (x[62:0] == 63'h0);
  endfunction
  function automatic logic is_inf(input logic [63:0] x);
    is_inf = (x[62:52] == EXP_ALL1) && (x[51:0] == 52'h0);
  endfunction
  function automatic logic is_snan(input logic [63:0] x);
    is_snan = (x[62:52] == EXP_ALL1) && !x[51] && (x[50:0] != 51'h0);
  endfunction
  function automatic logic is_qnan(input logic [63:0] x);
    is_qnan = (x[62:52] == EXP_ALL1) && x[51];
  endfunction
  // total order key, both zeros must still compare equal
  function automatic logic [63:0] order_key(input logic [63:0] x);
    order_key = x[63] ? ~x : {1'b1, x[62:0]};
  endfunction
  function automatic logic [5:0] lzc57(input logic [56:0] v);
    lzc57 = 6'h39;
    for (int i = 0; i <= 56; i++) begin
      if (v[i]) lzc57 = 6'(56 - i);
    end
  endfunction
  // truncating pack; range errors reported through the kind bits
  function automatic logic [65:0] pack_fp(input logic s,
                                          input logic signed [13:0] e,
                                          input logic [55:0] m);
    if (e <= 14'sh0000) pack_fp = {KIND_LO, s, 63'h0};
    else if (e >= EXP_INF) pack_fp = {KIND_HI, s, EXP_ALL1, 52'h0};
    else pack_fp = {KIND_OK, s, e[10:0], m[54:3]};
  endfunction
  function automatic op_t decode_op(input logic [31:0] w);
    decode_op = OP_NONE;
    if (w[31:26] == OPC_CMPL && (w[10:0] & FN_CMPL_MASK) == FN_CMPL)
      decode_op = OP_CMPL;
    else if (w[31:26] == OPC_FPU) begin
      if (w[10:0] == FN_DADD) decode_op = OP_DADD;
      else if (w[10:0] == FN_DRSUB) decode_op = OP_DRSUB;
      else if (w[10:0] == FN_DMUL) decode_op = OP_DMUL;
      else if (w[10:0] == FN_DDIV) decode_op = OP_DDIV;
      else if (w[10:7] == FN_DCMP_HI && w[3:0] == 4'h0 &&
               w[6:4] != 3'h7)
        decode_op = OP_DCMP;
    end
  endfunction
  function automatic logic [4:0] lat_of(input op_t op, input logic [1:0] md);
    logic [4:0] l;
    l = LAT_CMPL;
    if (op == OP_DDIV)
      l = (md == MODE_AREA) ? LAT_DIV_AREA :
          (md == MODE_FAST) ? LAT_DIV_FAST : LAT_DIV_SPD;
    else if (op == OP_DCMP)
      l = (md == MODE_AREA) ? LAT_DCMP_AREA :
          (md == MODE_FAST) ? LAT_DCMP_FAST : LAT_DCMP_SPD;
    else if (op != OP_CMPL)
      l = (md == MODE_AREA) ? LAT_ARITH_AREA :
          (md == MODE_FAST) ? LAT_ARITH_FAST : LAT_ARITH_SPD;
    lat_of = l;
  endfunction

  // reset release
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  logic [1:0]       mode_reg;
  logic [FLG_W-1:0] fp_status_reg;
  logic [4:0]       exception_status_reg;
  state_t           state_reg;
  logic [4:0]       cnt_reg;

  // issue decode
  op_t        c_op;
  logic [4:0] c_lat;
  logic       accept;
  cmp_type_t  compare_type_field;
  assign c_op   = decode_op(instr_i);
  assign c_lat  = lat_of(c_op, mode_reg);
  assign accept = issue_valid_i && state_reg == ST_IDLE && c_op != OP_NONE;
  assign compare_type_field = cmp_type_t'(instr_i[CMP_TYPE_LSB +: 3]);

  logic [63:0] opa;
  logic [63:0] opb;
  assign opa = src_a_i;
  assign opb = src_b_i;

  // add / reverse subtract: x = rB, y = +-rA
  logic [63:0]  ax, ay, al_v, as_v;
  logic [10:0]  d_exp;
  logic [5:0]   dsh;
  logic [111:0] wide;
  logic [55:0]  s_al;
  logic [56:0]  sum;
  logic [56:0]  sum_n;
  logic [5:0]   lz;
  logic [65:0]  add_pk;
  always_comb begin
    ax    = opb;
    ay    = (c_op == OP_DRSUB) ? {~opa[63], opa[62:0]} : opa;
    al_v  = (ax[62:0] >= ay[62:0]) ? ax : ay;
    as_v  = (ax[62:0] >= ay[62:0]) ? ay : ax;
    d_exp = al_v[62:52] - as_v[62:52];
    dsh   = (d_exp > 11'h03c) ? 6'h3c : d_exp[5:0];
    wide  = {1'b1, as_v[51:0], 59'h0} >> dsh;
    s_al  = {wide[111:57], wide[56] | (|wide[55:0])};
    if (al_v[63] == as_v[63])
      sum = {1'b0, 1'b1, al_v[51:0], 3'h0} + {1'b0, s_al};
    else
      sum = {1'b0, 1'b1, al_v[51:0], 3'h0} - {1'b0, s_al};
    lz    = lzc57(sum);
    sum_n = sum << lz;
    add_pk = pack_fp(al_v[63],
                     $signed({3'h0, al_v[62:52]}) + 14'sh0001 -
                     $signed({8'h00, lz}),
                     {sum_n[56:2], sum_n[1] | sum_n[0]});
    if (is_zero(ax) && is_zero(ay)) add_pk = {KIND_OK, ax[63] & ay[63], 63'h0};
    else if (is_zero(ax)) add_pk = {KIND_OK, ay};
    else if (is_zero(ay) || is_inf(ax)) add_pk = {KIND_OK, ax};
    else if (is_inf(ay)) add_pk = {KIND_OK, ay};
    else if (sum == 57'h0) add_pk = {KIND_OK, 64'h0};
  end

  // multiply and divide; the sign is shared
  logic         rs;
  logic [105:0] prod;
  logic [65:0]  mul_pk;
  logic [107:0] num, quo, rem;
  logic [52:0]  den;
  logic [65:0]  div_pk;
  always_comb begin
    rs   = opa[63] ^ opb[63];
    prod = {1'b1, opa[51:0]} * {1'b1, opb[51:0]};
    if (prod[105])
      mul_pk = pack_fp(rs, $signed({3'h0, opa[62:52]}) +
                       $signed({3'h0, opb[62:52]}) - BIAS + 14'sh0001,
                       {prod[105:51], |prod[50:0]});
    else
      mul_pk = pack_fp(rs, $signed({3'h0, opa[62:52]}) +
                       $signed({3'h0, opb[62:52]}) - BIAS,
                       {prod[104:50], |prod[49:0]});
    if (is_inf(opa) || is_inf(opb)) mul_pk = {KIND_OK, rs, EXP_ALL1, 52'h0};
    else if (is_zero(opa) || is_zero(opb)) mul_pk = {KIND_OK, rs, 63'h0};
    // rB / rA
    den = {1'b1, opa[51:0]};
    num = {1'b1, opb[51:0], 55'h0};
    quo = num / {55'h0, den};
    rem = num % {55'h0, den};
    if (quo[55])
      div_pk = pack_fp(rs, $signed({3'h0, opb[62:52]}) -
                       $signed({3'h0, opa[62:52]}) + BIAS,
                       {quo[55:1], quo[0] | (rem != 108'h0)});
    else
      div_pk = pack_fp(rs, $signed({3'h0, opb[62:52]}) -
                       $signed({3'h0, opa[62:52]}) + BIAS - 14'sh0001,
                       {quo[54:0], rem != 108'h0});
    if (is_inf(opb)) div_pk = {KIND_OK, rs, EXP_ALL1, 52'h0};
    else if (is_inf(opa) || is_zero(opb)) div_pk = {KIND_OK, rs, 63'h0};
  end

  // result selection in check priority order
  logic [63:0]      c_res;
  logic             c_wr;
  logic             c_exc;
  logic [FLG_W-1:0] c_flags;
  logic [65:0]      c_pk;
  logic             c_inval;
  logic             c_gt, c_lt, c_bit, c_anan;
  always_comb begin
    c_res   = 64'h0;
    c_wr    = 1'b0;
    c_exc   = 1'b0;
    c_flags = '0;
    c_bit   = 1'b0;
    c_gt    = order_key(opb) > order_key(opa);
    c_lt    = order_key(opb) < order_key(opa);
    if (is_zero(opa) && is_zero(opb)) begin
      c_gt = 1'b0;
      c_lt = 1'b0;
    end
    c_anan  = is_qnan(opa) || is_qnan(opb);
    c_pk    = (c_op == OP_DMUL) ? mul_pk :
              (c_op == OP_DDIV) ? div_pk : add_pk;
    c_inval = is_snan(opa) || is_snan(opb) ||
      (c_op == OP_DADD && is_inf(opa) && is_inf(opb) &&
       opa[63] != opb[63]) ||
      (c_op == OP_DRSUB && is_inf(opa) && is_inf(opb) &&
       opa[63] == opb[63]) ||
      (c_op == OP_DMUL && ((is_zero(opa) && is_inf(opb)) ||
                           (is_zero(opb) && is_inf(opa)))) ||
      (c_op == OP_DDIV && ((is_zero(opa) && is_zero(opb)) ||
                           (is_inf(opa) && is_inf(opb))));
    unique case (c_op)
      OP_NONE: ;
      OP_CMPL: begin
        c_res = opb - opa;
        c_res[63] = instr_i[CMPL_U_BIT] ? (opa > opb) :
                    ($signed(opa) > $signed(opb));
        c_wr  = 1'b1;
      end
      OP_DCMP: begin
        c_wr = 1'b1;
        if (is_dnz(opa) || is_dnz(opb)) begin
          c_flags[FLG_DO] = 1'b1;
          c_exc = 1'b1;
        end else if (is_snan(opa) || is_snan(opb) || c_anan) begin
          c_bit = compare_type_field inside {CT_UN, CT_NE};
          if (!(c_anan && !is_snan(opa) && !is_snan(opb) &&
                compare_type_field inside {CT_UN, CT_EQ, CT_NE})) begin
            c_flags[FLG_IO] = 1'b1;
            c_exc = 1'b1;
          end
        end else begin
          unique case (compare_type_field)
            CT_UN: c_bit = 1'b0;
            CT_LT: c_bit = c_lt;
            CT_EQ: c_bit = !c_lt && !c_gt;
            CT_LE: c_bit = !c_gt;
            CT_GT: c_bit = c_gt;
            CT_NE: c_bit = c_lt || c_gt;
            CT_GE: c_bit = !c_lt;
            default: c_bit = 1'b0;
          endcase
        end
        c_res = {63'h0, c_bit};
      end
      OP_DADD, OP_DRSUB, OP_DMUL, OP_DDIV: begin
        c_res = c_pk[63:0];
        if (is_dnz(opa) || is_dnz(opb)) begin
          c_flags[FLG_DO] = 1'b1;
          c_exc = 1'b1;
        end else if (c_inval) begin
          c_flags[FLG_IO] = 1'b1;
          c_exc = 1'b1;
        end else if (c_anan) begin
          c_res = QNAN;
          c_wr  = 1'b1;
        end else if (c_op == OP_DDIV && is_zero(opa) && !is_inf(opb)) begin
          c_res = {rs, EXP_ALL1, 52'h0};
          c_flags[FLG_DV] = 1'b1;
          c_exc = 1'b1;
        end else if (c_pk[65:64] == KIND_LO) begin
          c_flags[FLG_UN] = 1'b1;
          c_exc = 1'b1;
        end else if (c_pk[65:64] == KIND_HI) begin
          c_flags[FLG_OV] = 1'b1;
          c_exc = 1'b1;
        end else begin
          c_wr = 1'b1;
        end
      end
      default: ;
    endcase
  end

  // latency sequencer; a result computed at issue waits here
  logic [63:0]      pend_res;
  logic             pend_wr, pend_exc;
  logic [FLG_W-1:0] pend_flags;
  logic             emit;
  assign emit = (state_reg == ST_IDLE && accept && c_lat == LAT_CMPL) ||
                (state_reg == ST_RUN && cnt_reg == 5'h00);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 5'h00;
      pend_res   <= 64'h0;
      pend_wr    <= 1'b0;
      pend_exc   <= 1'b0;
      pend_flags <= '0;
    end else if (state_reg == ST_IDLE) begin
      if (accept && c_lat != LAT_CMPL) begin
        state_reg  <= ST_RUN;
        cnt_reg    <= c_lat - 5'h02;
        pend_res   <= c_res;
        pend_wr    <= c_wr;
        pend_exc   <= c_exc;
        pend_flags <= c_flags;
      end
    end else if (cnt_reg == 5'h00) begin
      state_reg <= ST_IDLE;
    end else begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end

  // outputs; busy holds off the issuing stage
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      wr_en_o  <= 1'b0;
      fp_exc_o <= 1'b0;
      result_o <= 64'h0;
    end else begin
      busy_o   <= (accept && c_lat != LAT_CMPL) ||
                  (state_reg == ST_RUN && !emit);
      done_o   <= emit;
      wr_en_o  <= emit && (state_reg == ST_IDLE ? c_wr : pend_wr);
      fp_exc_o <= emit && (state_reg == ST_IDLE ? c_exc : pend_exc);
      if (emit) result_o <= (state_reg == ST_IDLE) ? c_res : pend_res;
    end
  end

  // apb: one wait state, write lands on the edge that sees pready
  logic acc_ph, wr_hit, sts_clr;
  assign acc_ph  = psel_i && penable_i && !pready_o;
  assign wr_hit  = psel_i && penable_i && pready_o && pwrite_i;
  assign sts_clr = wr_hit && paddr_i == ADDR_STATUS;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= acc_ph;
      pslverr_o <= acc_ph && !(paddr_i inside {ADDR_CTRL, ADDR_STATUS,
                                               ADDR_CAUSE});
      prdata_o  <= 32'h0;
      if (acc_ph && !pwrite_i) begin
        unique case (paddr_i)
          ADDR_CTRL:   prdata_o <= {30'h0, mode_reg};
          ADDR_STATUS: prdata_o <= {27'h0, fp_status_reg};
          ADDR_CAUSE:  prdata_o <= {27'h0, exception_status_reg};
          default:     prdata_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) mode_reg <= MODE_RST;
    else if (wr_hit && paddr_i == ADDR_CTRL) mode_reg <= pwdata_i[1:0];
  end

  // sticky flags, write one to clear; a new event beats the clear
  logic [FLG_W-1:0] flg_set;
  assign flg_set = emit ? (state_reg == ST_IDLE ? c_flags : pend_flags) : '0;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) fp_status_reg <= STATUS_RST;
    else fp_status_reg <= (fp_status_reg &
                           ~(sts_clr ? pwdata_i[FLG_W-1:0] : '0)) | flg_set;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) exception_status_reg <= CAUSE_RST;
    else if (emit && (state_reg == ST_IDLE ? c_exc : pend_exc))
      exception_status_reg <= EXC_CAUSE_FP;
  end

  // operands of the last issue, for the checks below
  op_t         last_op;
  logic [63:0] last_a, last_b;
  logic        last_u;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      last_op <= OP_NONE;
      last_a  <= 64'h0;
      last_b  <= 64'h0;
      last_u  <= 1'b0;
    end else if (accept) begin
      last_op <= c_op;
      last_a  <= opa;
      last_b  <= opb;
      last_u  <= instr_i[CMPL_U_BIT];
    end
  end
  logic [63:0] chk_diff;
  logic        chk_arith;
  assign chk_diff  = last_b - last_a;
  assign chk_arith = last_op inside {OP_DADD, OP_DRSUB, OP_DMUL, OP_DDIV};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  AST_CMPL_LAT: assert property (
    accept && c_op == OP_CMPL |=> done_o && wr_en_o &&
      result_o[62:0] == chk_diff[62:0])
    else $error("long compare result not written after one cycle");
  AST_CMPL_MSB: assert property (
    done_o && last_op == OP_CMPL |-> result_o[63] ==
      (last_u ? last_a > last_b : $signed(last_a) > $signed(last_b)))
    else $error("long compare msb does not give the relation");
  AST_CMPL_SIGN: assert property (
    done_o && last_op == OP_CMPL && last_a[63] != last_b[63] |->
      result_o[63] == (last_u ? last_a[63] : last_b[63]))
    else $error("long compare sign mode wrong");
  AST_DNZ_FIRST: assert property (
    done_o && chk_arith && (is_dnz(last_a) || is_dnz(last_b)) |->
      fp_exc_o && fp_status_reg[FLG_DO] &&
      exception_status_reg == EXC_CAUSE_FP)
    else $error("denormal operand not reported");
  AST_NO_WRITE: assert property (
    fp_exc_o && last_op != OP_DCMP |-> !wr_en_o)
    else $error("destination written despite fp exception");
  AST_CAUSE_HOLD: assert property (
    $changed(exception_status_reg) |-> fp_exc_o)
    else $error("cause changed without an fp exception");
  AST_ARITH_LAT: assert property (
    accept && c_op != OP_DDIV && c_op != OP_DCMP && c_op != OP_CMPL &&
      mode_reg == MODE_SPEED |=> !done_o [*3] ##1 done_o)
    else $error("add, rsub or mul latency wrong");
  AST_DIV_LAT: assert property (
    accept && c_op == OP_DDIV && mode_reg == MODE_FAST |->
      ##24 done_o)
    else $error("divide latency wrong");
  AST_DIV_ZERO: assert property (
    done_o && last_op == OP_DDIV && is_zero(last_a) &&
      last_b[62:52] != 11'h000 && last_b[62:52] != EXP_ALL1 |->
      fp_exc_o && fp_status_reg[FLG_DV] && !wr_en_o)
    else $error("divide by zero not reported");
  AST_STALL: assert property (
    $fell(busy_o) |-> done_o)
    else $error("busy dropped without completion");

  COV_DIV: cover property (accept && c_op == OP_DDIV ##[1:40] done_o);
  COV_EXC: cover property (done_o && fp_exc_o);
  COV_CMPL: cover property (done_o && last_op == OP_CMPL);

endmodule

/* File: test/testbench.sv */
// self-checking bench for the long compare and double fpu path
`timescale 1ns/100ps
module testbench
  import fpu_pkg::*;
;
  logic        clk_sys_i = 0, rstn_i = 0, issue_valid_i = 0;
  logic [31:0] instr_i = 0, pwdata_i = 0, prdata_o;
  logic [63:0] src_a_i = 0, src_b_i = 0, result_o;
  logic        busy_o, done_o, wr_en_o, fp_exc_o, pready_o, pslverr_o;
  logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [4:0]  cause = 0;
  typedef struct {logic [63:0] r; logic ck, wr, ex; int lat;} note_t;
  note_t       q[$];
  int          err_total = 0, cmp_count = 0, cyc = 0, t_iss = 0;
  int          la[3] = '{4, 6, 1}, ld[3] = '{28, 30, 24}, lc[3] = '{1, 3, 1};
  localparam logic [63:0] ONE = 64'h3ff0000000000000;
  localparam logic [63:0] TWO = 64'h4000000000000000;
  localparam logic [63:0] THR = 64'h4008000000000000;
  localparam logic [63:0] SIX = 64'h4018000000000000;
  localparam logic [63:0] INF = 64'h7ff0000000000000;
  localparam logic [63:0] SGN = 64'h8000000000000000;

  long_compare_double_fpu DUT (.clk_sys_i, .rstn_i, .issue_valid_i,
    .instr_i, .src_a_i, .src_b_i, .busy_o, .done_o, .wr_en_o, .result_o,
    .fp_exc_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o);

  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // master waits for pready, no assumed wait-state count
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, e, input logic er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    if (!w) chk(64'(prdata_o), 64'(e));
    chk(64'(pslverr_o), 64'(er));
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task automatic iss(input logic [31:0] ins, input logic [63:0] a, b, r,
                     input logic ck, wr, ex, input int lat);
    @(posedge clk_sys_i);
    issue_valid_i <= 1;
    instr_i <= ins;
    src_a_i <= a;
    src_b_i <= b;
    q.push_back(note_t'{r, ck, wr, ex, lat});
  endtask

  task automatic settle;
    int n;
    n = 0;
    @(posedge clk_sys_i);
    issue_valid_i <= 0;
    while (q.size() > 0 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 100) err_total++;
  endtask

  function automatic logic [31:0] fi(input logic [10:0] f);
    return {OPC_FPU, 15'h0, f};
  endfunction

  // one op in speed mode, then status and cause over apb
  task automatic xc(input logic [10:0] f, input logic [63:0] a, b, r,
                    input logic ck, input logic [4:0] st);
    logic dc;
    dc = f[10:7] == FN_DCMP_HI;
    iss(fi(f), a, b, r, ck, st == 0 || dc, st != 0,
        f == FN_DDIV ? ld[0] : dc ? lc[0] : la[0]);
    settle;
    if (st != 0) cause = EXC_CAUSE_FP;
    apb(0, ADDR_STATUS, 0, 32'(st), 0);
    apb(0, ADDR_CAUSE, 0, 32'(cause), 0);
    apb(1, ADDR_STATUS, 32'(st), 0, 0);
  endtask

  always @(posedge clk_sys_i) begin
    note_t e;
    if (done_o === 1'b1) begin
      if (q.size() == 0) chk(64'(done_o), 64'h0);
      else begin
        e = q.pop_front();
        if (e.ck) chk(result_o, e.r);
        chk(64'(wr_en_o), 64'(e.wr));
        chk(64'(fp_exc_o), 64'(e.ex));
        chk(64'(cyc - t_iss), 64'(e.lat));
      end
    end
    if (issue_valid_i === 1'b1 && busy_o === 1'b0) t_iss = cyc;
    cyc++;
  end

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    conclude;
  end

  initial begin
    logic [63:0] a, b, d;
    logic        u;
    void'($urandom(55989));
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    apb(0, ADDR_CTRL, 0, 0, 0);
    apb(0, 12'h010, 0, 0, 1);
    $display("test registers done");
    // back to back, first pair overflows the subtraction
    for (int i = 0; i < 16; i++) begin
      a = i == 0 ? SGN : {$urandom, $urandom};
      b = i == 0 ? ~SGN : {$urandom, $urandom};
      u = $urandom;
      d = b - a;
      d[63] = u ? a > b : $signed(a) > $signed(b);
      iss({OPC_CMPL, 15'h0, FN_CMPL | {9'h0, u, 1'b0}}, a, b, d, 1, 1, 0, 1);
    end
    settle;
    $display("test long compare done");
    for (int m = 0; m < 3; m++) begin
      apb(1, ADDR_CTRL, 32'(m), 0, 0);
      apb(0, ADDR_CTRL, 0, 32'(m), 0);
      iss(fi(FN_DADD), ONE, TWO, THR, 1, 1, 0, la[m]);
      settle;
      iss(fi(FN_DRSUB), ONE, THR, TWO, 1, 1, 0, la[m]);
      settle;
      iss(fi(FN_DMUL), TWO, THR, SIX, 1, 1, 0, la[m]);
      settle;
      iss(fi(FN_DDIV), TWO, SIX, THR, 1, 1, 0, ld[m]);
      // issue held high while busy must be ignored
      repeat (3) @(posedge clk_sys_i);
      settle;
      for (int t = 0; t < 7; t++) begin
        iss(fi({FN_DCMP_HI, 3'(t), 4'h0}), ONE, TWO,
            64'(7'h70 >> t & 1), 1, 1, 0, lc[m]);
        settle;
      end
    end
    apb(1, ADDR_CTRL, 0, 0, 0);
    $display("test modes done");
    xc(FN_DADD, QNAN, ONE, QNAN, 1, 5'h00);
    xc(FN_DADD, 64'h1, INF | 64'h1, 0, 0, 5'h01);
    xc(FN_DADD, INF, INF | SGN, 0, 0, 5'h10);
    xc(FN_DRSUB, INF, INF, 0, 0, 5'h10);
    xc(FN_DMUL, 0, INF, 0, 0, 5'h10);
    xc(FN_DDIV, 0, 0, 0, 0, 5'h10);
    xc(FN_DDIV, 0, TWO | SGN, INF | SGN, 1, 5'h08);
    xc(FN_DMUL, 64'h7fefffffffffffff, TWO, INF, 1, 5'h04);
    xc(FN_DMUL, SGN | 64'h0010000000000000, 64'h0010000000000000,
       SGN, 1, 5'h02);
    xc({FN_DCMP_HI, 7'h40}, 64'h1, ONE, 0, 1, 5'h01);
    $display("test exceptions done");
    conclude;
  end
endmodule
